// ===== rtl/tssr_defines.vh
// constants for the timer sync signal router
//
// Overview of operation
// - after reset all timers run independently, no routing active
// - link control register reads and writes, cleared by reset and standby
// - source 00: horizontal in from spare, out follows in, vertical from vsync
// - source 01/10: composite or hsync in, out is clamp one, vertical is decode
// - source 11: horizontal in from hsync, out follows in, vertical from vsync
// - capture 00: own pins; 01: capture and reset vertical, clock horizontal
// - capture 10: capture and clock horizontal, reset vertical
// - capture 11: capture from timer one compare, clock horizontal, reset vertical
// - vertical invert bit inverts the vertical sync pin
// - horizontal invert bit inverts hsync and composite pins
// - output invert bit inverts both sync outputs
// - clamp select, link enable and output selects choose the clamp pin
// - source select, link enable and output selects choose hsync pin
// - edge detection on the sync input pins
// - link enable drives sync and clamp pins from the link outputs
// - edge flags set on rising edge, cleared by read-one then write-zero
`ifndef TSSR_DEFINES_VH
`define TSSR_DEFINES_VH
`define TSSR_ADDR_LINK_CTRL 16'hff9f
`define TSSR_ADDR_EDGE_FLAGS 16'hffa8
`define TSSR_ADDR_SERIAL_CTRL 16'hffc3
`define TSSR_ADDR_IRQ_MASK 16'hffa9
`define TSSR_RST_LINK_CTRL 8'h00
`define TSSR_RST_EDGE_FLAGS 8'h0f
`define TSSR_RST_SERIAL_CTRL 8'h00
`define TSSR_RST_IRQ_MASK 8'h00
`define TSSR_SRC_HI 7
`define TSSR_SRC_LO 6
`define TSSR_CLAMP_SEL 5
`define TSSR_VINV 4
`define TSSR_CAP_HI 3
`define TSSR_CAP_LO 2
`define TSSR_HINV 1
`define TSSR_OINV 0
`define TSSR_LINK_EN 4
`define TSSR_FLAG_V 7
`define TSSR_FLAG_H 6
`define TSSR_FLAG_C 5
`define TSSR_FLAG_F 4
`endif

// ===== rtl/tssr_timer_sync_signal_router.v
// timer sync signal router with avalon-mm register slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tssr_defines.vh"
module tssr_timer_sync_signal_router
(
  input wire clock_i,
  input wire reset_n_i,
  input wire standby_i,
  input wire [15:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire vertical_sync_in_i,
  input wire horizontal_sync_in_i,
  input wire composite_sync_in_i,
  input wire spare_sync_in_i,
  input wire free_timer_capture_pin_i,
  input wire byte_timer_one_clock_pin_i,
  input wire byte_timer_one_reset_pin_i,
  input wire byte_timer_one_compare_out_i,
  input wire pulse_width_decode_result_i,
  input wire clamp_wave_one_i,
  input wire clamp_wave_two_i,
  input wire byte_timer_x_compare_out_i,
  input wire free_counter_compare_b_out_i,
  input wire free_counter_output_enable_i,
  input wire [3:0] output_select_bits_one_i,
  input wire [3:0] output_select_bits_x_i,
  output reg free_timer_capture_in_o,
  output reg byte_timer_one_clock_in_o,
  output reg byte_timer_one_reset_in_o,
  output reg vertical_sync_out_o,
  output reg vertical_sync_out_en_o,
  output reg horizontal_sync_out_o,
  output reg horizontal_sync_out_en_o,
  output reg clamp_out_o,
  output reg clamp_out_en_o,
  output reg irq_o
);
  // ****************************************
  // reset release
  // ****************************************
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] link_ctrl_reg;
  reg [7:0] serial_ctrl_reg;
  reg [7:0] edge_flags_reg;
  reg [7:0] irq_mask_reg;
  reg [7:0] read_word_next;
  reg [3:0] flag_seen_reg;
  reg [3:0] pins_prev_reg;
  reg ack_reg;

  // ****************************************
  // decode helpers
  // ****************************************
  function addr_hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // selectable phase inversion of one sync level
  function phase;
    input level;
    input invert;
    begin
      phase = level ^ invert;
    end
  endfunction

  wire req = (avs_read_i | avs_write_i) & ~ack_reg;
  wire wr = avs_write_i & ~ack_reg;
  wire rd = avs_read_i & ~ack_reg;
  wire sel_link = addr_hit(avs_address_i, `TSSR_ADDR_LINK_CTRL);
  wire sel_edge = addr_hit(avs_address_i, `TSSR_ADDR_EDGE_FLAGS);
  wire sel_ser = addr_hit(avs_address_i, `TSSR_ADDR_SERIAL_CTRL);
  wire sel_mask = addr_hit(avs_address_i, `TSSR_ADDR_IRQ_MASK);
  wire hold = !rst_n || standby_i;

  // ****************************************
  // input inversion and edge detection
  // ****************************************
  wire vsync_in = phase(vertical_sync_in_i, link_ctrl_reg[`TSSR_VINV]);
  wire hsync_in = phase(horizontal_sync_in_i, link_ctrl_reg[`TSSR_HINV]);
  wire csync_in = phase(composite_sync_in_i, link_ctrl_reg[`TSSR_HINV]);
  wire [3:0] pins_now = {vertical_sync_in_i, horizontal_sync_in_i,
    composite_sync_in_i, spare_sync_in_i};
  wire [3:0] rise;
  wire [3:0] clr;
  wire [3:0] flags_next;
  wire clr_strobe = wr & sel_edge;

  // set wins over clear; a zero write clears only a flag read while set
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_edge
      assign rise[gi] = pins_now[gi] & ~pins_prev_reg[gi];
      assign clr[gi] = clr_strobe & flag_seen_reg[gi] & ~avs_writedata_i[gi + 4];
      assign flags_next[gi] = (edge_flags_reg[gi + 4] & ~clr[gi]) | rise[gi];
    end
  endgenerate

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pins_prev_reg <= 4'h0;
    else
      pins_prev_reg <= pins_now;
  end

  // ****************************************
  // edge flags and their clear handshake
  // ****************************************
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      edge_flags_reg <= `TSSR_RST_EDGE_FLAGS;
      flag_seen_reg <= 4'h0;
    end
    else if (hold)
    begin
      edge_flags_reg <= `TSSR_RST_EDGE_FLAGS;
      flag_seen_reg <= 4'h0;
    end
    else
    begin
      edge_flags_reg <= {flags_next, 4'hf};
      if (rd && sel_edge)
        flag_seen_reg <= edge_flags_reg[7:4];
      else if (clr_strobe)
        flag_seen_reg <= 4'h0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      link_ctrl_reg <= `TSSR_RST_LINK_CTRL;
      serial_ctrl_reg <= `TSSR_RST_SERIAL_CTRL;
      irq_mask_reg <= `TSSR_RST_IRQ_MASK;
    end
    else if (hold)
    begin
      link_ctrl_reg <= `TSSR_RST_LINK_CTRL;
      serial_ctrl_reg <= `TSSR_RST_SERIAL_CTRL;
      irq_mask_reg <= `TSSR_RST_IRQ_MASK;
    end
    else
    begin
      if (wr && sel_link)
        link_ctrl_reg <= avs_writedata_i[7:0];
      if (wr && sel_ser)
        serial_ctrl_reg <= avs_writedata_i[7:0];
      if (wr && sel_mask)
        irq_mask_reg <= {avs_writedata_i[7:4], 4'h0};
    end
  end

  // ****************************************
  // bus handshake and read data
  // ****************************************
  always @*
  begin
    read_word_next = 8'h00;
    if (sel_link)
      read_word_next = link_ctrl_reg;
    else if (sel_edge)
      read_word_next = edge_flags_reg;
    else if (sel_ser)
      read_word_next = serial_ctrl_reg;
    else if (sel_mask)
      read_word_next = irq_mask_reg;
  end

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_reg <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
    end
    else if (hold)
    begin
      ack_reg <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
    end
    else
    begin
      ack_reg <= req;
      avs_waitrequest_o <= ~req;
      if (rd)
        avs_readdata_o <= {24'h000000, read_word_next};
    end
  end

  // ****************************************
  // sync source and capture routing
  // ****************************************
  wire [1:0] src = {link_ctrl_reg[`TSSR_SRC_HI], link_ctrl_reg[`TSSR_SRC_LO]};
  wire [1:0] cap = {link_ctrl_reg[`TSSR_CAP_HI], link_ctrl_reg[`TSSR_CAP_LO]};
  wire link_en = serial_ctrl_reg[`TSSR_LINK_EN];
  reg int_h_in;
  reg int_h_out;
  reg int_v;
  reg cap_n;
  reg clk_n;
  reg rst_n_t;
  always @*
  begin
    case (src)
      2'b00:
      begin
        int_h_in = spare_sync_in_i;
        int_h_out = int_h_in;
        int_v = vsync_in;
      end
      2'b01:
      begin
        int_h_in = csync_in;
        int_h_out = clamp_wave_one_i;
        int_v = pulse_width_decode_result_i;
      end
      2'b10:
      begin
        int_h_in = hsync_in;
        int_h_out = clamp_wave_one_i;
        int_v = pulse_width_decode_result_i;
      end
      default:
      begin
        int_h_in = hsync_in;
        int_h_out = int_h_in;
        int_v = vsync_in;
      end
    endcase
    case (cap)
      2'b00:
      begin
        cap_n = free_timer_capture_pin_i;
        clk_n = byte_timer_one_clock_pin_i;
        rst_n_t = byte_timer_one_reset_pin_i;
      end
      2'b01:
      begin
        cap_n = int_v;
        clk_n = int_h_in;
        rst_n_t = int_v;
      end
      2'b10:
      begin
        cap_n = int_h_in;
        clk_n = int_h_in;
        rst_n_t = int_v;
      end
      default:
      begin
        cap_n = byte_timer_one_compare_out_i;
        clk_n = int_h_in;
        rst_n_t = int_v;
      end
    endcase
  end

  // ****************************************
  // output pin functions
  // ****************************************
  wire os1_any = |output_select_bits_one_i;
  wire osx_any = |output_select_bits_x_i;
  wire oinv = link_ctrl_reg[`TSSR_OINV];
  wire clamp_sel = link_ctrl_reg[`TSSR_CLAMP_SEL] ? clamp_wave_two_i : clamp_wave_one_i;
  wire unmasked = |(edge_flags_reg[7:4] & irq_mask_reg[7:4]);

  // routed timer inputs, one cycle behind the pins
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      free_timer_capture_in_o <= 1'b0;
      byte_timer_one_clock_in_o <= 1'b0;
      byte_timer_one_reset_in_o <= 1'b0;
    end
    else
    begin
      free_timer_capture_in_o <= cap_n;
      byte_timer_one_clock_in_o <= clk_n;
      byte_timer_one_reset_in_o <= rst_n_t;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= unmasked;
  end

  // vertical sync pin
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vertical_sync_out_o <= 1'b0;
      vertical_sync_out_en_o <= 1'b0;
    end
    else if (link_en)
    begin
      vertical_sync_out_o <= phase(int_v, oinv);
      vertical_sync_out_en_o <= 1'b1;
    end
    else
    begin
      vertical_sync_out_o <= free_counter_compare_b_out_i;
      vertical_sync_out_en_o <= free_counter_output_enable_i;
    end
  end

  // horizontal sync pin
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      horizontal_sync_out_o <= 1'b0;
      horizontal_sync_out_en_o <= 1'b0;
    end
    else if (link_en)
    begin
      horizontal_sync_out_o <= phase(int_h_out, oinv);
      horizontal_sync_out_en_o <= 1'b1;
    end
    else
    begin
      horizontal_sync_out_o <= byte_timer_one_compare_out_i;
      horizontal_sync_out_en_o <= os1_any;
    end
  end

  // clamp pin
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      clamp_out_o <= 1'b0;
      clamp_out_en_o <= 1'b0;
    end
    else if (link_en)
    begin
      clamp_out_o <= clamp_sel;
      clamp_out_en_o <= 1'b1;
    end
    else
    begin
      clamp_out_o <= byte_timer_x_compare_out_i;
      clamp_out_en_o <= osx_any;
    end
  end
endmodule // tssr_timer_sync_signal_router
`default_nettype wire

// ===== dv/tssr_partner.sv
// far-side model: sync sources and timer levels
`timescale 1ns/1ps
`default_nettype none
module tssr_partner
(
  input wire logic clock_i,
  input wire logic [13:0] pat_i,
  output logic [13:0] lvl_o
);
  // levels change only just after a clock edge
  always @(posedge clock_i)
  begin
    lvl_o <= pat_i;
  end
endmodule // tssr_partner
`default_nettype wire

// ===== dv/tssr_monitor.sv
// port checks for the sync router
`timescale 1ns/1ps
`default_nettype none
module tssr_monitor
(
  input wire clock_i,
  input wire reset_n_i,
  input wire standby_i,
  input wire [15:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire free_timer_capture_pin_i,
  input wire free_counter_output_enable_i,
  input wire [3:0] output_select_bits_one_i,
  input wire [3:0] output_select_bits_x_i,
  input wire free_timer_capture_in_o,
  input wire vertical_sync_out_en_o,
  input wire horizontal_sync_out_en_o,
  input wire clamp_out_en_o,
  input wire irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low two cycles");
  read_answer_a: assert property ($rose(avs_read_i) |-> ##1 !avs_waitrequest_o)
    else $error("read not answered");
  write_answer_a: assert property ($rose(avs_write_i) |-> ##1 !avs_waitrequest_o)
    else $error("write not answered");
  upper_zero_a: assert property (!avs_waitrequest_o && avs_read_i |->
    avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
  unmapped_read_a: assert property (!avs_waitrequest_o && avs_read_i &&
    avs_address_i == 16'h0000 |-> avs_readdata_o == 32'h0) else $error("unmapped read");
  idle_route_a: assert property (standby_i ##1 standby_i |=>
    free_timer_capture_in_o == $past(free_timer_capture_pin_i)) else $error("capture route");
  idle_pins_a: assert property (standby_i ##1 standby_i |=>
    clamp_out_en_o == ($past(output_select_bits_x_i) != 0) &&
    horizontal_sync_out_en_o == ($past(output_select_bits_one_i) != 0) &&
    vertical_sync_out_en_o == $past(free_counter_output_enable_i)) else $error("pin enables");
  idle_irq_a: assert property (standby_i ##1 standby_i |=> !irq_o)
    else $error("irq after standby");
endmodule // tssr_monitor
bind tssr_timer_sync_signal_router tssr_monitor mon
(
  .clock_i, .reset_n_i, .standby_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .free_timer_capture_pin_i,
  .free_counter_output_enable_i, .output_select_bits_one_i, .output_select_bits_x_i,
  .free_timer_capture_in_o, .vertical_sync_out_en_o, .horizontal_sync_out_en_o,
  .clamp_out_en_o, .irq_o
);
`default_nettype wire

// ===== dv/tssr_timer_sync_signal_router_bench.sv
// self-checking bench for the sync router
`timescale 1ns/1ps
`default_nettype none
`include "tssr_defines.vh"
module tssr_timer_sync_signal_router_bench;
  logic clock_i, reset_n_i, standby_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [15:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [3:0] output_select_bits_one_i, output_select_bits_x_i;
  logic [13:0] pat, lvl;
  logic [8:0] q;
  int errors, num_checks;
  tssr_partner far (.clock_i, .pat_i(pat), .lvl_o(lvl));
  tssr_timer_sync_signal_router DUT
  (
    .*,
    .vertical_sync_in_i(lvl[0]),
    .horizontal_sync_in_i(lvl[1]),
    .composite_sync_in_i(lvl[2]),
    .spare_sync_in_i(lvl[3]),
    .free_timer_capture_pin_i(lvl[4]),
    .byte_timer_one_clock_pin_i(lvl[5]),
    .byte_timer_one_reset_pin_i(lvl[6]),
    .byte_timer_one_compare_out_i(lvl[7]),
    .pulse_width_decode_result_i(lvl[8]),
    .clamp_wave_one_i(lvl[9]),
    .clamp_wave_two_i(lvl[10]),
    .byte_timer_x_compare_out_i(lvl[11]),
    .free_counter_compare_b_out_i(lvl[12]),
    .free_counter_output_enable_i(lvl[13]),
    .free_timer_capture_in_o(q[8]),
    .byte_timer_one_clock_in_o(q[7]),
    .byte_timer_one_reset_in_o(q[6]),
    .vertical_sync_out_o(q[5]),
    .horizontal_sync_out_o(q[4]),
    .clamp_out_o(q[3]),
    .vertical_sync_out_en_o(q[2]),
    .horizontal_sync_out_en_o(q[1]),
    .clamp_out_en_o(q[0])
  );
  initial
  begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic end_of_test;
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_read_i <= !w;
    avs_write_i <= w;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clock_i);
    rd = avs_readdata_o;
    avs_read_i <= 0;
    avs_write_i <= 0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1, a, d);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    chk("readdata", {24'h0, e}, rd);
  endtask
  // expected {capture, clock, reset, vsync, hsync, clamp} with link output on
  function automatic logic [5:0] route(input logic [7:0] t, input logic [13:0] p);
    logic vi, hi, ci, internal_horizontal_in, internal_horizontal_out, iv;
    vi = p[0] ^ t[4];
    hi = p[1] ^ t[1];
    ci = p[2] ^ t[1];
    internal_horizontal_in = t[7:6] == 0 ? p[3] : t[7:6] == 1 ? ci : hi;
    iv = t[7] ^ t[6] ? p[8] : vi;
    internal_horizontal_out = t[7] ^ t[6] ? p[9] : internal_horizontal_in;
    return {t[3:2] == 0 ? p[4] : t[3:2] == 1 ? iv : t[3:2] == 2 ? internal_horizontal_in : p[7],
      t[3:2] == 0 ? p[5] : internal_horizontal_in, t[3:2] == 0 ? p[6] : iv, iv ^ t[0], internal_horizontal_out ^ t[0],
      t[5] ? p[10] : p[9]};
  endfunction
  initial
  begin
    #200000;
    errors++;
    end_of_test;
  end
  initial
  begin
    errors = 0;
    num_checks = 0;
    reset_n_i = 0;
    standby_i = 0;
    avs_read_i = 0;
    avs_write_i = 0;
    avs_address_i = 0;
    avs_writedata_i = 0;
    pat = 0;
    output_select_bits_one_i = 4'h3;
    output_select_bits_x_i = 4'h0;
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1;
    repeat (4) @(posedge clock_i);
    rdc(`TSSR_ADDR_LINK_CTRL, 8'h00);
    rdc(`TSSR_ADDR_EDGE_FLAGS, 8'h0f);
    rdc(`TSSR_ADDR_SERIAL_CTRL, 8'h00);
    rdc(`TSSR_ADDR_IRQ_MASK, 8'h00);
    wr(16'h0000, 8'h5a);
    rdc(16'h0000, 8'h00);
    pat <= 14'h2890;
    repeat (3) @(posedge clock_i);
    chk("pins", 9'h11e, q);
    wr(`TSSR_ADDR_SERIAL_CTRL, 8'h10);
    for (int i = 0; i < 1024; i++)
    begin
      pat <= 14'((i >> 2) * 1877 ^ i * 77);
      wr(`TSSR_ADDR_LINK_CTRL, i[7:0]);
      repeat (3) @(posedge clock_i);
      chk("route", {route(i[7:0], pat), 3'b111}, q);
    end
    rdc(`TSSR_ADDR_LINK_CTRL, 8'hff);
    pat <= 0;
    rdc(`TSSR_ADDR_EDGE_FLAGS, 8'hff);
    wr(`TSSR_ADDR_EDGE_FLAGS, 8'h00);
    rdc(`TSSR_ADDR_EDGE_FLAGS, 8'h0f);
    wr(`TSSR_ADDR_IRQ_MASK, 8'h40);
    pat <= 14'h3;
    repeat (4) @(posedge clock_i);
    chk("irq", 1, irq_o);
    rdc(`TSSR_ADDR_EDGE_FLAGS, 8'hcf);
    wr(`TSSR_ADDR_EDGE_FLAGS, 8'h80);
    rdc(`TSSR_ADDR_EDGE_FLAGS, 8'h8f);
    repeat (2) @(posedge clock_i);
    chk("irq", 0, irq_o);
    wr(`TSSR_ADDR_EDGE_FLAGS, 8'h70);
    rdc(`TSSR_ADDR_EDGE_FLAGS, 8'h0f);
    pat <= 0;
    repeat (2) @(posedge clock_i);
    pat <= 14'h2;
    repeat (4) @(posedge clock_i);
    chk("irq", 1, irq_o);
    standby_i <= 1;
    repeat (3) @(posedge clock_i);
    standby_i <= 0;
    @(posedge clock_i);
    rdc(`TSSR_ADDR_LINK_CTRL, 8'h00);
    rdc(`TSSR_ADDR_SERIAL_CTRL, 8'h00);
    end_of_test;
  end
endmodule // tssr_timer_sync_signal_router_bench
`default_nettype wire
